// ---- src/adcst_defines.svh ----
// Summary of operation
// R1 - any write to sequence start register aborts current sequence, starts new one
// R2 - with hardware trigger on, triggers only launch after one start write
// R3 - conversion start is the beginning of the sampling phase
// R4 - special input enable bit 6 allows select code to pick internal inputs
// R5 - bit 5 picks single or repeated sequences; ignored under hardware trigger
// R6 - bit 4 clear samples one input; set samples across inputs, length field
// R7 - select code is first input; increments, wraps after limit, or 7 to 0
// R8 - twelve done flags indexed by sequence position; result n in register n
// R9 - compare enabled: flag only if compare true, request irq, drop result
// R10 - flag clears by start write, write 1, fast read, or fast write
// R11 - start write clear beats set; other clears lose to set
// R12 - edge trigger: polarity 0 falling, 1 rising; each edge one sequence
// R13 - level trigger: polarity 0 low, 1 high; convert while level active
// R14 - first conversion begins when the trigger is received
// R15 - edge mode: extra trigger during conversion sets overrun flag
// R16 - level mode: trigger drop and return never sets overrun flag
// R17 - level mode: trigger active at sequence end starts another at once
// R18 - software enables trigger pin input buffer before hardware triggering
// R19 - pins always feed the mux; digital buffer switched per pin by register
// R20 - after reset flags clear, overrun clear, no sequence runs
`ifndef ADCST_DEFINES_SVH
`define ADCST_DEFINES_SVH

// register indexes; byte address is four times the index
`define ADCST_IDX_ROLLOVER  6'h00
`define ADCST_IDX_TRIGCFG   6'h01
`define ADCST_IDX_START     6'h05
`define ADCST_IDX_TRIGSTAT  6'h06
`define ADCST_IDX_DONE      6'h0A
`define ADCST_IDX_CMPEN     6'h0C
`define ADCST_IDX_CMPOP     6'h0D
`define ADCST_IDX_DIEN      6'h0E
`define ADCST_IDX_RESULT0   6'h10
`define ADCST_IDX_RESULT11  6'h1B

// sequence start control fields
`define ADCST_START_SC      6
`define ADCST_START_SCAN    5
`define ADCST_START_CROSS_INPUT_SAMPLING    4

// trigger configuration fields
`define ADCST_CFG_HWEN      0
`define ADCST_CFG_LVL       1
`define ADCST_CFG_POL       2
`define ADCST_CFG_FAST_FLAG_CLEAR      3
`define ADCST_CFG_LEN_LSB   4
`define ADCST_CFG_CIE       8

// trigger status fields
`define ADCST_STAT_OVR      0
`define ADCST_STAT_ACTIVE   1
`define ADCST_STAT_ARMED    2

// sizes and reset values
`define ADCST_SLOTS         12
`define ADCST_LAST_LOW_CH   4'h7
`define ADCST_RST_WRAP      4'hF
`define ADCST_RST_ZERO4     4'h0

`endif

// ---- src/adcst_pkg.sv ----
`include "adcst_defines.svh"

package adcst_pkg;

  // sequence engine states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ARMED   = 2'b01,
    ST_CONVERT = 2'b10
  } adcst_seq_t;

  // converter front-end request
  typedef struct packed {
    logic       sample_start;
    logic       abort;
    logic       special;
    logic [3:0] channel;
  } adcst_conv_req_t;

  // converter front-end answer
  typedef struct packed {
    logic        done;
    logic [15:0] result;
  } adcst_conv_ans_t;

  // whole state of the block
  typedef struct packed {
    logic                         dph_valid;
    logic                         dph_write;
    logic [5:0]                   dph_idx;
    logic                         rd_wait;
    logic [31:0]                  hrdata;
    logic [3:0]                   wrap;
    logic [8:0]                   cfg;
    logic [6:0]                   ctl;
    logic [`ADCST_SLOTS-1:0]      flags;
    logic                         ovr;
    logic [`ADCST_SLOTS-1:0]      compare_enable_bits;
    logic [`ADCST_SLOTS-1:0]      cmpop;
    logic [15:0]                  dien;
    logic [`ADCST_SLOTS-1:0][15:0] result;
    adcst_seq_t                   seq;
    logic [3:0]                   ch;
    logic [3:0]                   pos;
    logic                         trig_s1;
    logic                         trig_s2;
    logic                         trig_q;
    adcst_conv_req_t              req;
    logic                         cmp_irq;
  } adcst_state_t;

endpackage

// ---- src/adcst_top.sv ----
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "adcst_defines.svh"

module adcst_top
  import adcst_pkg::*;
#(
  parameter int RES_W = 12,  // converter result width
  parameter int PIN_W = 16   // number of input pins
) (
  input  wire logic             hclk,        // bus clock
  input  wire logic             hresetn,     // async reset, low active
  input  wire logic             hsel,        // slave select
  input  wire logic [31:0]      haddr,       // byte address
  input  wire logic [1:0]       htrans,      // transfer type
  input  wire logic             hwrite,      // write when high
  input  wire logic [2:0]       hsize,       // transfer size
  input  wire logic [31:0]      hwdata,      // write data
  input  wire logic             hready,      // bus ready in
  output logic                  hreadyout,   // slave ready
  output logic                  hresp,       // always okay
  output logic [31:0]           hrdata,      // read data
  input  wire logic             trig_pin,    // external trigger pin
  output adcst_conv_req_t       conv_req,    // converter request
  input  wire adcst_conv_ans_t  conv_ans,    // converter answer
  output logic                  cmp_irq,     // compare interrupt request
  output logic [PIN_W-1:0]      din_buf_en   // digital buffer enables
);

  // parameter range check
  if (RES_W < 1 || RES_W > 16) begin : g_res_chk
    $error("RES_W must lie between 1 and 16");
  end
  if (PIN_W < 1 || PIN_W > 16) begin : g_pin_chk
    $error("PIN_W must lie between 1 and 16");
  end

  adcst_state_t st;
  adcst_state_t next_st;

  // conversions per sequence; zero or too large means all slots
  function automatic logic [3:0] fn_seq_count(input logic [3:0] len);
    if (len == 4'h0 || len > 4'(`ADCST_SLOTS)) begin
      fn_seq_count = 4'(`ADCST_SLOTS);
    end else begin
      fn_seq_count = len;
    end
  endfunction

  // next input in a cross-input sequence
  function automatic logic [3:0] fn_next_ch(input logic [3:0] ch,
                                            input logic [3:0] lim);
    if (ch == lim) begin
      fn_next_ch = 4'h0;  // R7
    end else if (ch > lim && ch >= `ADCST_LAST_LOW_CH) begin
      fn_next_ch = 4'h0;  // R7
    end else begin
      fn_next_ch = 4'(ch + 4'h1);  // R7
    end
  endfunction

  // result register index decode
  function automatic logic fn_is_result(input logic [5:0] idx);
    fn_is_result = (idx >= `ADCST_IDX_RESULT0) &&
                   (idx <= `ADCST_IDX_RESULT11);
  endfunction

  // slot number of a result register index
  function automatic logic [3:0] fn_slot(input logic [5:0] idx);
    logic [5:0] d;
    d = 6'(idx - `ADCST_IDX_RESULT0);
    fn_slot = d[3:0];
  endfunction

  // trigger decode from the synchronised pin
  logic trig_active;
  logic trig_edge;
  logic hw_en;
  logic lvl_mode;
  always_comb begin
    hw_en    = st.cfg[`ADCST_CFG_HWEN];
    lvl_mode = st.cfg[`ADCST_CFG_LVL];
    if (st.cfg[`ADCST_CFG_POL]) begin
      trig_active = st.trig_s2;                // R13
      trig_edge   = st.trig_s2 & ~st.trig_q;   // R12
    end else begin
      trig_active = ~st.trig_s2;               // R13
      trig_edge   = ~st.trig_s2 & st.trig_q;   // R12
    end
  end

  // next state of everything
  always_comb begin
    logic                    addr_ok;
    logic                    wr_now;
    logic [5:0]              widx;
    logic                    start_wr;
    logic [`ADCST_SLOTS-1:0] set_m;
    logic [`ADCST_SLOTS-1:0] clr_m;
    logic                    ovr_set;
    logic                    ovr_clr;
    logic                    launch;
    logic [3:0]              slot;
    logic [3:0]              rslot;
    logic [15:0]             res;
    logic                    cmp_true;
    logic [31:0]             rd;
    logic [3:0]              cnt;
    addr_ok  = 1'b0;
    wr_now   = 1'b0;
    widx     = 6'h00;
    start_wr = 1'b0;
    set_m    = '0;
    clr_m    = '0;
    ovr_set  = 1'b0;
    ovr_clr  = 1'b0;
    launch   = 1'b0;
    slot     = st.pos;
    rslot    = 4'h0;
    res      = 16'h0000;
    cmp_true = 1'b0;
    rd       = 32'h0000_0000;
    cnt      = fn_seq_count(st.cfg[`ADCST_CFG_LEN_LSB +: 4]);
    next_st  = st;

    // one-cycle pulses fall back each cycle
    next_st.req.sample_start = 1'b0;
    next_st.req.abort        = 1'b0;
    next_st.cmp_irq          = 1'b0;

    // trigger pin synchroniser and edge history
    next_st.trig_s1 = trig_pin;
    next_st.trig_s2 = st.trig_s1;
    next_st.trig_q  = st.trig_s2;

    // bus address phase
    addr_ok = hsel & htrans[1] & hready;
    if (addr_ok) begin
      next_st.dph_valid = 1'b1;
      next_st.dph_write = hwrite;
      next_st.dph_idx   = haddr[7:2];
      next_st.rd_wait   = ~hwrite;
    end else if (hready) begin
      next_st.dph_valid = 1'b0;
      next_st.dph_write = 1'b0;
    end

    // bus write data phase
    wr_now = st.dph_valid & st.dph_write;
    widx   = st.dph_idx;
    if (wr_now) begin
      case (widx)
        `ADCST_IDX_ROLLOVER: begin
          next_st.wrap = hwdata[3:0];
        end
        `ADCST_IDX_TRIGCFG: begin
          next_st.cfg = hwdata[8:0];
        end
        `ADCST_IDX_START: begin
          next_st.ctl = hwdata[6:0];
          start_wr    = 1'b1;  // R1
        end
        `ADCST_IDX_TRIGSTAT: begin
          ovr_clr = hwdata[`ADCST_STAT_OVR];
        end
        `ADCST_IDX_DONE: begin
          if (!st.cfg[`ADCST_CFG_FAST_FLAG_CLEAR]) begin
            clr_m = clr_m | hwdata[`ADCST_SLOTS-1:0];  // R10
          end
        end
        `ADCST_IDX_CMPEN: begin
          next_st.compare_enable_bits = hwdata[`ADCST_SLOTS-1:0];
        end
        `ADCST_IDX_CMPOP: begin
          next_st.cmpop = hwdata[`ADCST_SLOTS-1:0];
        end
        `ADCST_IDX_DIEN: begin
          next_st.dien = hwdata[15:0];  // R19
        end
        default: begin
          if (fn_is_result(widx)) begin
            rslot = fn_slot(widx);
            next_st.result[rslot] = hwdata[15:0];
            if (st.cfg[`ADCST_CFG_FAST_FLAG_CLEAR] && st.compare_enable_bits[rslot]) begin
              clr_m[rslot] = 1'b1;  // R10
            end
          end
        end
      endcase
    end

    // bus read: one wait state, then registered data
    if (st.rd_wait) begin
      next_st.rd_wait = 1'b0;
      case (st.dph_idx)
        `ADCST_IDX_ROLLOVER: rd[3:0] = st.wrap;
        `ADCST_IDX_TRIGCFG:  rd[8:0] = st.cfg;
        `ADCST_IDX_START:    rd[6:0] = st.ctl;
        `ADCST_IDX_TRIGSTAT: begin
          rd[`ADCST_STAT_OVR]    = st.ovr;
          rd[`ADCST_STAT_ACTIVE] = (st.seq == ST_CONVERT);
          rd[`ADCST_STAT_ARMED]  = (st.seq == ST_ARMED);
        end
        `ADCST_IDX_DONE:  rd[`ADCST_SLOTS-1:0] = st.flags;  // R8
        `ADCST_IDX_CMPEN: rd[`ADCST_SLOTS-1:0] = st.compare_enable_bits;
        `ADCST_IDX_CMPOP: rd[`ADCST_SLOTS-1:0] = st.cmpop;
        `ADCST_IDX_DIEN:  rd[15:0] = st.dien;
        default: begin
          if (fn_is_result(st.dph_idx)) begin
            rslot     = fn_slot(st.dph_idx);
            rd[15:0]  = st.result[rslot];
            if (st.cfg[`ADCST_CFG_FAST_FLAG_CLEAR] && !st.compare_enable_bits[rslot]) begin
              clr_m[rslot] = 1'b1;  // R10
            end
          end
        end
      endcase
      next_st.hrdata = rd;
    end

    // sequence engine
    case (st.seq)
      ST_IDLE: begin
        next_st.seq = ST_IDLE;
      end
      ST_ARMED: begin
        if (!hw_en) begin
          next_st.seq = ST_IDLE;
        end else if (lvl_mode ? trig_active : trig_edge) begin
          launch = 1'b1;  // R14
        end
      end
      ST_CONVERT: begin
        if (hw_en && !lvl_mode && trig_edge) begin
          ovr_set = 1'b1;  // R15 R16
        end
        if (conv_ans.done) begin
          slot = st.pos;
          res  = 16'(conv_ans.result[RES_W-1:0]);
          if (st.compare_enable_bits[slot]) begin
            if (st.cmpop[slot]) begin
              cmp_true = res > st.result[slot];
            end else begin
              cmp_true = res <= st.result[slot];
            end
            set_m[slot]     = cmp_true;  // R9
            next_st.cmp_irq = cmp_true & st.cfg[`ADCST_CFG_CIE];  // R9
          end else begin
            next_st.result[slot] = res;  // R8
            set_m[slot]          = 1'b1;  // R8
          end
          if (4'(st.pos + 4'h1) >= cnt) begin
            if (hw_en) begin
              if (lvl_mode && trig_active) begin
                launch = 1'b1;  // R17
              end else begin
                next_st.seq = ST_ARMED;  // R5 R12
              end
            end else if (st.ctl[`ADCST_START_SCAN]) begin
              launch = 1'b1;  // R5
            end else begin
              next_st.seq = ST_IDLE;  // R5
            end
          end else begin
            next_st.pos              = 4'(st.pos + 4'h1);
            next_st.req.sample_start = 1'b1;  // R3
            if (st.ctl[`ADCST_START_CROSS_INPUT_SAMPLING]) begin
              next_st.ch = fn_next_ch(st.ch, st.wrap);  // R6
            end
          end
        end
      end
      default: begin
        next_st.seq = ST_IDLE;
      end
    endcase

    // start write overrides any sequence in progress
    if (start_wr) begin
      next_st.req.abort = (st.seq == ST_CONVERT);  // R1
      launch            = 1'b0;
      if (hw_en) begin
        next_st.seq = ST_ARMED;  // R2
      end else begin
        launch = 1'b1;  // R1
      end
    end

    // begin a fresh sequence at position zero
    if (launch) begin
      next_st.seq              = ST_CONVERT;
      next_st.pos              = 4'h0;
      next_st.req.sample_start = 1'b1;  // R3
      if (start_wr) begin
        next_st.ch = hwdata[3:0];  // R7
      end else begin
        next_st.ch = st.ctl[3:0];  // R7
      end
    end

    // special inputs reachable only with the enable bit set
    if (start_wr) begin
      next_st.req.special = hwdata[`ADCST_START_SC];  // R4
    end else begin
      next_st.req.special = st.ctl[`ADCST_START_SC];  // R4
    end
    next_st.req.channel = next_st.ch;

    // done flags: start clear wins, other clears lose to set
    if (start_wr) begin
      next_st.flags = '0;  // R11
    end else begin
      next_st.flags = (st.flags & ~clr_m) | set_m;  // R11
    end

    // overrun flag: set wins over software clear
    next_st.ovr = (st.ovr & ~ovr_clr) | ovr_set;  // R15
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st       <= '0;  // R20
      st.wrap  <= `ADCST_RST_WRAP;
      st.seq   <= ST_IDLE;  // R20
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign hreadyout  = ~st.rd_wait;
  assign hresp      = 1'b0;
  assign hrdata     = st.hrdata;
  assign conv_req   = st.req;
  assign cmp_irq    = st.cmp_irq;
  assign din_buf_en = st.dien[PIN_W-1:0];  // R19

endmodule  // adcst_top

// ---- tb/adcst_chk.sv ----
`timescale 1ns/1ps
`include "adcst_defines.svh"

module adcst_chk
  import adcst_pkg::*;
#(
  parameter int PIN_W = 16  // pin count
) (
  input wire logic             hclk,       // bus clock
  input wire logic             hresetn,    // async reset
  input wire logic             hsel,       // select
  input wire logic [31:0]      haddr,      // address
  input wire logic [1:0]       htrans,     // transfer type
  input wire logic             hwrite,     // write
  input wire logic [31:0]      hwdata,     // write data
  input wire logic             hready,     // ready in
  input wire logic             hreadyout,  // ready out
  input wire logic             hresp,      // response
  input wire adcst_conv_req_t  conv_req,   // converter request
  input wire logic             cmp_irq,    // compare request
  input wire logic [PIN_W-1:0] din_buf_en  // buffer enables
);

  logic taken;
  logic wr_q;
  logic st_q;
  logic started;

  // transfer accepted at this edge
  assign taken = hsel & htrans[1] & hready;

  // data-phase markers; started stays set after a start write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      st_q    <= 1'b0;
      started <= 1'b0;
    end else begin
      wr_q    <= taken & hwrite;
      st_q    <= taken & hwrite & (haddr[7:2] == `ADCST_IDX_START);
      started <= started | st_q;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  start_gate_a: assert property (conv_req.sample_start |-> started)
    else $error("conversion before any start write");
  abort_cause_a: assert property (conv_req.abort |-> $past(st_q))
    else $error("abort without start write");
  sample_pulse_a: assert property (conv_req.sample_start |=> !conv_req.sample_start)
    else $error("sample start longer than a cycle");
  special_bit_a: assert property ($past(st_q) |-> conv_req.special == $past(hwdata[6]))
    else $error("special select not taken from start write");
  first_input_a: assert property (conv_req.sample_start && $past(st_q) |-> conv_req.channel == $past(hwdata[3:0]))
    else $error("first input not the select code");
  irq_pulse_a: assert property (cmp_irq |=> !cmp_irq)
    else $error("compare request longer than a cycle");
  din_write_a: assert property (!$stable(din_buf_en) |-> $past(wr_q))
    else $error("buffer enables changed without write");

  // main scenarios reached
  cover property (taken && !hwrite);
  cover property (conv_req.abort);
  cover property (cmp_irq);

endmodule  // adcst_chk

bind adcst_top adcst_chk #(.PIN_W(PIN_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .conv_req(conv_req),
  .cmp_irq(cmp_irq), .din_buf_en(din_buf_en)
);

// ---- tb/adcst_conv_model.sv ----
`timescale 1ns/1ps

module adcst_conv_model
  import adcst_pkg::*;
(
  input  wire logic            hclk,     // bus clock
  input  wire logic            hresetn,  // async reset
  input  wire adcst_conv_req_t req,      // request
  input  wire logic [7:0]      dly,      // conversion time
  output adcst_conv_ans_t      ans       // answer
);

  logic [7:0]  cnt;
  logic [3:0]  ch;
  logic [15:0] val;

  // one conversion at a time; abort drops it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      ch  <= 4'h0;
    end else if (req.sample_start) begin
      cnt <= dly;
      ch  <= req.channel;
    end else if (req.abort) begin
      cnt <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  // result names its input; inverted except while the count is at one
  assign val = {8'h00, ch, ch};
  // an aborted conversion never answers, even on its last cycle
  assign ans = {(cnt == 8'h01) & ~req.abort, (cnt == 8'h01) ? val : ~val};

endmodule  // adcst_conv_model

// ---- tb/adcst_tb_top.sv ----
`timescale 1ns/1ps
`include "adcst_defines.svh"

module adcst_tb_top
  import adcst_pkg::*;
;

  logic            hclk;
  logic            hresetn;
  logic            hsel;
  logic [31:0]     haddr;
  logic [1:0]      htrans;
  logic            hwrite;
  logic [2:0]      hsize;
  logic [31:0]     hwdata;
  logic            hreadyout;
  logic            hresp;
  logic [31:0]     hrdata;
  logic            trig_pin;
  adcst_conv_req_t conv_req;
  adcst_conv_ans_t conv_ans;
  logic            cmp_irq;
  logic [15:0]     din_buf_en;
  logic [7:0]      dly;
  logic [31:0]     v;
  logic [3:0]      c;
  int              failures;
  int              checked;
  int              cyc;
  int              irq_n;
  int              ss_n;
  int              st [2] = '{3, 5};

  adcst_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .trig_pin(trig_pin), .conv_req(conv_req),
    .conv_ans(conv_ans), .cmp_irq(cmp_irq), .din_buf_en(din_buf_en)
  );

  adcst_conv_model u_conv (
    .hclk(hclk), .hresetn(hresetn), .req(conv_req), .dly(dly),
    .ans(conv_ans)
  );

  // clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // pulse counters and hang limit
  always @(posedge hclk) begin
    cyc++;
    if (conv_req.sample_start === 1'b1) ss_n++;
    if (cmp_irq === 1'b1) irq_n++;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end

  task complete_run;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // hready is looked at before the edge that samples it
  task wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
  endtask

  task wr(input logic [5:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= 32'(i) << 2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask

  task rd(input logic [5:0] i, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= 32'(i) << 2;
    wait_rdy;
    htrans <= 2'h0;
    wait_rdy;
    d = hrdata;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task rc(input logic [5:0] i, input logic [31:0] e);
    rd(i, v);
    chk(v, e);
  endtask

  // read until the value arrives or the tries run out
  task poll(input logic [5:0] i, input logic [31:0] e);
    int n;
    n = 0;
    rd(i, v);
    while (v !== e && n < 100) begin
      rd(i, v);
      n++;
    end
    chk(v, e);
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hsize = 3'h2;
    trig_pin = 1'b0;
    dly = 8'h03;
    tick(8);
    hresetn <= 1'b1;
    tick(1);
    rc(`ADCST_IDX_DONE, 32'h0000_0000);
    rc(`ADCST_IDX_TRIGSTAT, 32'h0000_0000);
    rc(`ADCST_IDX_ROLLOVER, 32'h0000_000F);
    wr(6'h02, 32'hFFFF_FFFF);
    rc(6'h02, 32'h0000_0000);
    wr(`ADCST_IDX_DIEN, 32'h0000_A5A5);
    rc(`ADCST_IDX_DIEN, 32'h0000_A5A5);
    chk({16'h0000, din_buf_en}, 32'h0000_A5A5);
    wr(`ADCST_IDX_TRIGCFG, 32'h0000_0020);
    wr(`ADCST_IDX_START, 32'h0000_0003);
    poll(`ADCST_IDX_DONE, 32'h0000_0003);
    rc(`ADCST_IDX_RESULT0 + 6'h01, 32'h0000_0033);
    wr(`ADCST_IDX_ROLLOVER, 32'h0000_0004);
    wr(`ADCST_IDX_TRIGCFG, 32'h0000_0040);
    foreach (st[j]) begin
      wr(`ADCST_IDX_START, 32'h0000_0010 | 32'(st[j]));
      poll(`ADCST_IDX_DONE, 32'h0000_000F);
      c = 4'(st[j]);
      for (int k = 0; k < 4; k++) begin
        rc(6'(`ADCST_IDX_RESULT0 + k), {24'h00_0000, c, c});
        c = (c == 4'h4 || (c > 4'h4 && c >= 4'h7)) ? 4'h0 : c + 4'h1;
      end
    end
    wr(`ADCST_IDX_DONE, 32'h0000_0001);
    rc(`ADCST_IDX_DONE, 32'h0000_000E);
    dly <= 8'h28;
    wr(`ADCST_IDX_START, 32'h0000_0013);
    rc(`ADCST_IDX_DONE, 32'h0000_0000);
    wr(`ADCST_IDX_START, 32'h0000_0015);
    poll(`ADCST_IDX_DONE, 32'h0000_000F);
    rc(`ADCST_IDX_RESULT0, 32'h0000_0055);
    dly <= 8'h03;
    wr(`ADCST_IDX_TRIGCFG, 32'h0000_0048);
    wr(`ADCST_IDX_START, 32'h0000_0013);
    poll(`ADCST_IDX_DONE, 32'h0000_000F);
    rc(`ADCST_IDX_RESULT0, 32'h0000_0033);
    rc(`ADCST_IDX_DONE, 32'h0000_000E);
    wr(`ADCST_IDX_CMPEN, 32'h0000_0001);
    wr(`ADCST_IDX_CMPOP, 32'h0000_0001);
    wr(`ADCST_IDX_RESULT0, 32'h0000_0001);
    wr(`ADCST_IDX_TRIGCFG, 32'h0000_0118);
    irq_n = 0;
    wr(`ADCST_IDX_START, 32'h0000_0003);
    poll(`ADCST_IDX_DONE, 32'h0000_0001);
    rc(`ADCST_IDX_RESULT0, 32'h0000_0001);
    chk(32'(irq_n), 32'h0000_0001);
    wr(`ADCST_IDX_RESULT0, 32'h0000_0001);
    rc(`ADCST_IDX_DONE, 32'h0000_0000);
    wr(`ADCST_IDX_CMPOP, 32'h0000_0000);
    wr(`ADCST_IDX_START, 32'h0000_0003);
    tick(12);
    rc(`ADCST_IDX_DONE, 32'h0000_0000);
    chk(32'(irq_n), 32'h0000_0001);
    wr(`ADCST_IDX_CMPEN, 32'h0000_0000);
    for (int p = 0; p < 2; p++) begin
      trig_pin <= ~1'(p);
      wr(`ADCST_IDX_TRIGCFG, 32'h0000_0011 | 32'(p << 2));
      wr(`ADCST_IDX_START, 32'h0000_0003);
      tick(10);
      rc(`ADCST_IDX_DONE, 32'h0000_0000);
      trig_pin <= 1'(p);
      poll(`ADCST_IDX_DONE, 32'h0000_0001);
    end
    dly <= 8'h28;
    wr(`ADCST_IDX_START, 32'h0000_0003);
    trig_pin <= 1'b0;
    tick(4);
    trig_pin <= 1'b1;
    tick(12);
    trig_pin <= 1'b0;
    tick(4);
    trig_pin <= 1'b1;
    tick(6);
    rd(`ADCST_IDX_TRIGSTAT, v);
    chk(v & 32'h0000_0001, 32'h0000_0001);
    wr(`ADCST_IDX_TRIGSTAT, 32'h0000_0001);
    rd(`ADCST_IDX_TRIGSTAT, v);
    chk(v & 32'h0000_0001, 32'h0000_0000);
    dly <= 8'h03;
    trig_pin <= 1'b0;
    wr(`ADCST_IDX_TRIGCFG, 32'h0000_0017);
    wr(`ADCST_IDX_START, 32'h0000_0003);
    ss_n = 0;
    trig_pin <= 1'b1;
    tick(40);
    trig_pin <= 1'b0;
    tick(2);
    trig_pin <= 1'b1;
    tick(20);
    trig_pin <= 1'b0;
    tick(20);
    chk(32'(ss_n > 4), 32'h0000_0001);
    rd(`ADCST_IDX_TRIGSTAT, v);
    chk(v & 32'h0000_0001, 32'h0000_0000);
    // software start with special inputs and repeated sequences
    wr(`ADCST_IDX_TRIGCFG, 32'h0000_0010);
    ss_n = 0;
    wr(`ADCST_IDX_START, 32'h0000_0063);
    tick(40);
    chk(32'(ss_n > 4), 32'h0000_0001);
    chk(32'(conv_req.special), 32'h0000_0001);
    wr(`ADCST_IDX_START, 32'h0000_0003);
    poll(`ADCST_IDX_DONE, 32'h0000_0001);
    chk(32'(conv_req.special), 32'h0000_0000);
    ss_n = 0;
    tick(20);
    chk(32'(ss_n), 32'h0000_0000);
    complete_run;
  end

endmodule  // adcst_tb_top
